/* File: hw/sliu_pkg.sv */
// Constants, layouts and carrier types of the sixteen-level interrupt unit
package sliu_pkg;

  localparam int          NUM_LEVELS   = 16;
  localparam int          LVL_W        = 4;
  localparam int          DATA_W       = 16;
  localparam int          ADDR_W       = 4;

  // Vector location of level n is base plus four times n
  localparam logic [15:0] VECTOR_BASE  = 16'h0400;
  localparam int          VECTOR_SHIFT = 2;

  // Levels with special handling
  localparam int          LVL_POWER_DOWN = 0;
  localparam int          LVL_MACHINE    = 1;
  localparam int          LVL_BRANCH_EXE = 5;

  // Levels that follow the source level instead of its rising edge
  localparam logic [15:0] LEVEL_SENSE    = 16'h0068;
  // Levels that ignore the enable mask
  localparam logic [15:0] NO_MASK        = 16'h0021;
  // Levels that ignore the user interrupt disable
  localparam logic [15:0] NO_DISABLE     = 16'h0023;
  // Levels cleared by master reset
  localparam logic [15:0] MASTER_RESET_IN_CLEAR     = 16'h0021;

  // Register offsets
  localparam logic [3:0]  OFS_PENDING    = 4'h0;
  localparam logic [3:0]  OFS_ENA_MASK   = 4'h1;
  localparam logic [3:0]  OFS_SAVE       = 4'h2;
  localparam logic [3:0]  OFS_CONTROL    = 4'h3;
  localparam logic [3:0]  OFS_EVT_STATUS = 4'h4;
  localparam logic [3:0]  OFS_EVT_MASK   = 4'h5;

  // Control register fields
  localparam int          CTL_USER_EN    = 0;
  localparam int          CTL_RISC_MODE  = 1;

  // Event status fields
  localparam int          EVT_TAKEN      = 0;
  localparam int          EVT_OVERWRITE  = 1;
  localparam int          EVT_W          = 2;

  // Reset values
  localparam logic [15:0] RST_PENDING    = 16'h0000;
  localparam logic [15:0] RST_ENA_MASK   = 16'h0000;
  localparam logic [15:0] RST_SAVE       = 16'h0000;
  localparam logic        RST_USER_EN    = 1'b0;
  localparam logic        RST_RISC_MODE  = 1'b1;
  localparam logic [1:0]  RST_EVT        = 2'h0;

  typedef enum logic [1:0] {
    SLIU_IDLE,
    SLIU_SAVE,
    SLIU_DISABLE,
    SLIU_LOAD
  } sliu_state_t;

  // Interrupt sources, one per level
  typedef struct packed {
    logic user_irq_line_5;
    logic io_level_two_irq;
    logic user_irq_line_4;
    logic io_level_one_irq;
    logic user_irq_line_3;
    logic user_irq_line_2;
    logic timer_b;
    logic user_irq_line_1;
    logic timer_a;
    logic float_underflow;
    logic branch_exec;
    logic fixed_overflow;
    logic float_overflow;
    logic user_irq_line_0;
    logic machine_error;
    logic power_down;
  } sliu_src_t;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } sliu_bus_req_t;

  // Vector handed to the sequencer
  typedef struct packed {
    logic        load;
    logic [3:0]  level;
    logic [15:0] addr;
  } sliu_vector_t;

endpackage

/* File: hw/sliu_top.sv */
// Sixteen-level prioritised interrupt unit with counter save and vectoring
`timescale 1ns/10ps
module sliu_top (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic                   master_reset_in,
  input  wire sliu_pkg::sliu_src_t    src,
  input  wire logic [15:0]            instr_counter,
  input  wire logic                   seq_ready,
  input  wire logic                   call_instr,
  input  wire sliu_pkg::sliu_bus_req_t bus_req,
  output logic [15:0]                 reg_rdata,
  output sliu_pkg::sliu_vector_t      vector,
  output logic                        irq_out
);

  logic [15:0]           pending_irq_reg;
  logic [15:0]           irq_enable_mask_reg;
  logic [15:0]           counter_save_reg;
  logic                  user_irq_enable;
  logic                  risc_mode;
  logic [1:0]            evt_status;
  logic [1:0]            evt_mask;
  logic                  save_unread;
  logic [15:0]           raw_vec;
  logic [15:0]           prev_raw;
  logic [15:0]           set_vec;
  logic [15:0]           eligible;
  logic [15:0]           next_pending;
  logic [3:0]            sel_level;
  logic [3:0]            held_level;
  logic                  take_go;
  logic                  wr_hit;
  logic                  rd_hit;
  logic [1:0]            evt_set;
  sliu_pkg::sliu_state_t state;
  sliu_pkg::sliu_state_t next_state;

  assign wr_hit = bus_req.wr;
  assign rd_hit = bus_req.rd;

  assign raw_vec = src;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prev_raw <= 16'h0000;
    end else begin
      prev_raw <= raw_vec;
    end
  end

  assign set_vec = (raw_vec & sliu_pkg::LEVEL_SENSE)
                 | (raw_vec & ~prev_raw & ~sliu_pkg::LEVEL_SENSE);

  assign eligible = pending_irq_reg
                  & (irq_enable_mask_reg | sliu_pkg::NO_MASK)
                  & (user_irq_enable ? 16'hFFFF : sliu_pkg::NO_DISABLE);

  always_comb begin
    sel_level = 4'h0;
    for (int i = sliu_pkg::NUM_LEVELS - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        sel_level = 4'(i);
      end
    end
  end

  assign take_go = (state == sliu_pkg::SLIU_IDLE) && risc_mode && seq_ready
                 && (eligible != 16'h0000);

  always_comb begin
    next_state = state;
    unique case (state)
      sliu_pkg::SLIU_IDLE: begin
        if (take_go) begin
          next_state = sliu_pkg::SLIU_SAVE;
        end
      end
      sliu_pkg::SLIU_SAVE:    next_state = sliu_pkg::SLIU_DISABLE;
      sliu_pkg::SLIU_DISABLE: next_state = sliu_pkg::SLIU_LOAD;
      sliu_pkg::SLIU_LOAD:    next_state = sliu_pkg::SLIU_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state      <= sliu_pkg::SLIU_IDLE;
      held_level <= 4'h0;
    end else begin
      state <= next_state;
      if (take_go) begin
        held_level <= sel_level;
      end
    end
  end

  // Set beats software and take clears; master reset beats set
  always_comb begin
    next_pending = pending_irq_reg;
    if (wr_hit && bus_req.addr == sliu_pkg::OFS_PENDING) begin
      next_pending = next_pending & ~bus_req.wdata;
    end
    if (state == sliu_pkg::SLIU_LOAD) begin
      next_pending[held_level] = 1'b0;
    end
    next_pending = next_pending | set_vec;
    if (master_reset_in) begin
      next_pending = next_pending & ~sliu_pkg::MASTER_RESET_IN_CLEAR;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pending_irq_reg <= sliu_pkg::RST_PENDING;
    end else begin
      pending_irq_reg <= next_pending;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      counter_save_reg <= sliu_pkg::RST_SAVE;
    end else if (state == sliu_pkg::SLIU_SAVE || call_instr) begin
      counter_save_reg <= instr_counter;
    end
  end

  // Unread tracking lets software see a lost return address
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      save_unread <= 1'b0;
    end else if (state == sliu_pkg::SLIU_SAVE || call_instr) begin
      save_unread <= 1'b1;
    end else if (rd_hit && bus_req.addr == sliu_pkg::OFS_SAVE) begin
      save_unread <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      user_irq_enable <= sliu_pkg::RST_USER_EN;
      risc_mode       <= sliu_pkg::RST_RISC_MODE;
    end else begin
      if (state == sliu_pkg::SLIU_DISABLE) begin
        user_irq_enable <= 1'b0;
      end else if (wr_hit && bus_req.addr == sliu_pkg::OFS_CONTROL) begin
        user_irq_enable <= bus_req.wdata[sliu_pkg::CTL_USER_EN];
      end
      if (wr_hit && bus_req.addr == sliu_pkg::OFS_CONTROL) begin
        risc_mode <= bus_req.wdata[sliu_pkg::CTL_RISC_MODE];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_enable_mask_reg <= sliu_pkg::RST_ENA_MASK;
      evt_mask            <= sliu_pkg::RST_EVT;
    end else if (wr_hit) begin
      if (bus_req.addr == sliu_pkg::OFS_ENA_MASK) begin
        irq_enable_mask_reg <= bus_req.wdata;
      end
      if (bus_req.addr == sliu_pkg::OFS_EVT_MASK) begin
        evt_mask <= bus_req.wdata[sliu_pkg::EVT_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vector <= '0;
    end else begin
      vector.load <= (state == sliu_pkg::SLIU_DISABLE);
      if (state == sliu_pkg::SLIU_DISABLE) begin
        vector.level <= held_level;
        vector.addr  <= sliu_pkg::VECTOR_BASE
                      + (16'(held_level) << sliu_pkg::VECTOR_SHIFT);
      end
    end
  end

  // Events: taken interrupt, and a save that replaced an unread address
  assign evt_set = {(state == sliu_pkg::SLIU_SAVE || call_instr) && save_unread,
                    state == sliu_pkg::SLIU_LOAD};

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      evt_status <= sliu_pkg::RST_EVT;
    end else if (wr_hit && bus_req.addr == sliu_pkg::OFS_EVT_STATUS) begin
      evt_status <= (evt_status & ~bus_req.wdata[sliu_pkg::EVT_W-1:0]) | evt_set;
    end else begin
      evt_status <= evt_status | evt_set;
    end
  end

  // Follows status by one cycle, since output must be a flop
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt_status & evt_mask);
    end
  end

  // Unmapped offsets read zero
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (rd_hit) begin
      unique case (bus_req.addr)
        sliu_pkg::OFS_PENDING:    reg_rdata <= pending_irq_reg;
        sliu_pkg::OFS_ENA_MASK:   reg_rdata <= irq_enable_mask_reg;
        sliu_pkg::OFS_SAVE:       reg_rdata <= counter_save_reg;
        sliu_pkg::OFS_CONTROL:    reg_rdata <= {14'h0000, risc_mode, user_irq_enable};
        sliu_pkg::OFS_EVT_STATUS: reg_rdata <= {14'h0000, evt_status};
        sliu_pkg::OFS_EVT_MASK:   reg_rdata <= {14'h0000, evt_mask};
        default:                  reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_save_done;
    counter_save_reg == $past(instr_counter);
  endsequence

  // Load pulse and the cleared enable land on the same cycle
  sequence s_disabled_with_load;
    !user_irq_enable && vector.load;
  endsequence

  take_sequence_a: assert property (
    take_go ##1 !call_instr |=> s_save_done ##1 s_disabled_with_load)
    else $error("take sequence not save, disable, load");

  vector_location_a: assert property (
    vector.load |-> vector.addr == 16'h0400 + {10'h000, vector.level, 2'b00})
    else $error("vector location wrong");

  // Delayed copy lines the eligible set up with the load it chose
  logic [15:0] eligible_past3;
  always_ff @(posedge mclk) begin
    eligible_past3 <= $past(eligible, 2);
  end

  highest_first_a: assert property (
    take_go |-> ##3 (vector.load && vector.level == $past(sel_level, 3)
                && ((eligible_past3 & ~(16'hFFFF << vector.level)) == 16'h0000)))
    else $error("lower priority serviced first");

  master_clear_a: assert property (
    master_reset_in |=> !pending_irq_reg[0] && !pending_irq_reg[5])
    else $error("master reset left level zero or five pending");

  edge_only_a: assert property (
    !$past(sys_rst) && raw_vec[2] && $past(raw_vec[2]) && !pending_irq_reg[2]
    |=> !pending_irq_reg[2])
    else $error("edge level latched without an edge");

  level_latch_a: assert property (
    raw_vec[3] && !master_reset_in |=> pending_irq_reg[3])
    else $error("active level not latched");

  never_masked_a: assert property (
    pending_irq_reg[0] && state == sliu_pkg::SLIU_IDLE && risc_mode && seq_ready
    |=> state == sliu_pkg::SLIU_SAVE ##3 vector.level == 4'h0)
    else $error("level zero not serviced");

  disable_scope_a: assert property (
    take_go && !user_irq_enable |-> sel_level inside {4'h0, 4'h1, 4'h5})
    else $error("disabled level taken");

  mask_gate_a: assert property (
    take_go && !irq_enable_mask_reg[sel_level] |-> sel_level inside {4'h0, 4'h5})
    else $error("masked level taken");

  call_save_a: assert property (
    call_instr |=> counter_save_reg == $past(instr_counter))
    else $error("call did not save counter");

  overwrite_flag_a: assert property (
    state == sliu_pkg::SLIU_SAVE && save_unread |=> evt_status[sliu_pkg::EVT_OVERWRITE])
    else $error("overwrite of unread save not flagged");

  pend_clear_a: assert property (
    state == sliu_pkg::SLIU_LOAD && !set_vec[held_level] |=> !pending_irq_reg[held_level])
    else $error("taken level still pending");

  pend_hold_a: assert property (
    pending_irq_reg[9] && !(state == sliu_pkg::SLIU_LOAD && held_level == 4'h9)
    && !(wr_hit && bus_req.addr == sliu_pkg::OFS_PENDING)
    |=> pending_irq_reg[9])
    else $error("untaken level lost its pending bit");

  edge_latch_a: assert property (
    raw_vec[2] && !$past(raw_vec[2]) |=> pending_irq_reg[2])
    else $error("rising edge not latched");

  load_pulse_a: assert property (
    vector.load |=> !vector.load)
    else $error("vector load longer than one cycle");

  disable_step_a: assert property (
    state == sliu_pkg::SLIU_DISABLE |=> !user_irq_enable)
    else $error("disable step left interrupts enabled");

  no_take_a: assert property (
    !risc_mode && state == sliu_pkg::SLIU_IDLE |=> state == sliu_pkg::SLIU_IDLE)
    else $error("take started outside risc mode");

endmodule

/* File: dv/sliu_seq_model.sv */
// Sequencer model: holds the instruction counter, jumps on vector load or call
`timescale 1ns/10ps
module sliu_seq_model #(
  parameter logic [15:0] START_IC = 16'h1234
) (
  input  wire logic                   mclk,
  input  wire logic                   sys_rst,
  input  wire logic                   call_instr,
  input  wire sliu_pkg::sliu_vector_t vector,
  output logic [15:0]                 instr_counter
);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      instr_counter <= START_IC;
    end else if (vector.load) begin
      instr_counter <= vector.addr;
    end else if (call_instr) begin
      // Jump target is arbitrary, only needs to differ
      instr_counter <= instr_counter + 16'h0100;
    end
  end
endmodule

/* File: dv/sixteen_level_irq_unit_test.sv */
// Self-checking bench of the sixteen-level interrupt unit
`timescale 1ns/10ps
module sixteen_level_irq_unit_test;
  logic                    mclk            = 1'b0;
  logic                    sys_rst         = 1'b1;
  logic                    master_reset_in = 1'b0;
  sliu_pkg::sliu_src_t     src             = '0;
  logic                    seq_ready       = 1'b1;
  logic                    call_instr      = 1'b0;
  sliu_pkg::sliu_bus_req_t bus_req         = '0;
  logic [15:0]             reg_rdata;
  sliu_pkg::sliu_vector_t  vector;
  logic                    irq_out;
  logic [15:0]             instr_counter;
  logic [15:0]             exp_ic          = 16'h1234;
  logic [15:0]             save_exp;
  int                      n_mismatch      = 0;
  int                      tests_run       = 0;

  always #50 mclk = ~mclk;

  sliu_top sliu_top_i (
    .mclk(mclk), .sys_rst(sys_rst), .master_reset_in(master_reset_in), .src(src),
    .instr_counter(instr_counter), .seq_ready(seq_ready), .call_instr(call_instr),
    .bus_req(bus_req), .reg_rdata(reg_rdata), .vector(vector), .irq_out(irq_out));

  sliu_seq_model sliu_seq_model_i (
    .mclk(mclk), .sys_rst(sys_rst), .call_instr(call_instr), .vector(vector),
    .instr_counter(instr_counter));

  task automatic wrap_up();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req <= '0;
    @(negedge mclk);
    cmp("reg_rdata", exp, reg_rdata);
  endtask

  task automatic pulse(input logic [15:0] bits);
    @(posedge mclk);
    src <= bits;
    repeat (2) @(posedge mclk);
    src <= '0;
  endtask

  task automatic wait_load(input int n);
    int i;
    for (i = 0; i < 20 && vector.load !== 1'b1; i++) @(negedge mclk);
    if (vector.load !== 1'b1) begin
      cmp("vector.load", 16'h0001, 16'h0000);
      wrap_up();
    end else begin
      cmp("vector.level", 16'(n), 16'(vector.level));
      cmp("vector.addr", 16'h0400 + 16'(n * 4), vector.addr);
      save_exp = exp_ic;
      exp_ic   = 16'h0400 + 16'(n * 4);
    end
  endtask

  task automatic irq_chk(input logic e);
    @(posedge mclk);
    @(negedge mclk);
    cmp("irq_out", 16'(e), 16'(irq_out));
  endtask

  task automatic t_reset();
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0000);
    rd(4'h3, 16'h0002);
    rd(4'h5, 16'h0000);
    rd(4'hF, 16'h0000);
  endtask

  task automatic t_vectors();
    int n;
    wr(4'h1, 16'hFFFF);
    for (n = 0; n < 16; n++) begin
      wr(4'h3, 16'h0003);
      pulse(16'h0001 << n);
      wait_load(n);
      rd(4'h0, 16'h0000);
      rd(4'h2, save_exp);
      rd(4'h3, 16'h0002);
    end
  endtask

  task automatic t_priority();
    wr(4'h3, 16'h0003);
    pulse(16'h0204);
    wait_load(2);
    rd(4'h0, 16'h0200);
    rd(4'h4, 16'h0001);
    wr(4'h3, 16'h0003);
    wait_load(9);
    rd(4'h2, save_exp);
    rd(4'h4, 16'h0003);
  endtask

  task automatic t_disable();
    wr(4'h3, 16'h0002);
    pulse(16'h0006);
    wait_load(1);
    rd(4'h0, 16'h0004);
    wr(4'h1, 16'h0000);
    pulse(16'h0020);
    wait_load(5);
    rd(4'h0, 16'h0004);
    wr(4'h1, 16'hFFFF);
    wr(4'h3, 16'h0003);
    wait_load(2);
  endtask

  task automatic t_mask();
    int i;
    wr(4'h1, 16'h0000);
    wr(4'h3, 16'h0003);
    pulse(16'h0010);
    for (i = 0; i < 10; i++) begin
      @(negedge mclk);
      cmp("vector.load", 16'h0000, 16'(vector.load));
    end
    rd(4'h0, 16'h0010);
    wr(4'h0, 16'h0010);
    rd(4'h0, 16'h0000);
  endtask

  task automatic t_master_reset_in();
    wr(4'h3, 16'h0000);
    pulse(16'h0025);
    rd(4'h0, 16'h0025);
    @(posedge mclk) master_reset_in <= 1'b1;
    @(posedge mclk) master_reset_in <= 1'b0;
    rd(4'h0, 16'h0004);
    wr(4'h0, 16'h0004);
  endtask

  task automatic t_sense();
    @(posedge mclk) src <= 16'h000C;
    wr(4'h0, 16'h000C);
    rd(4'h0, 16'h0008);
    @(posedge mclk) src <= 16'h0000;
    wr(4'h0, 16'h0008);
    rd(4'h0, 16'h0000);
  endtask

  task automatic t_call();
    @(posedge mclk) call_instr <= 1'b1;
    @(posedge mclk) call_instr <= 1'b0;
    rd(4'h2, exp_ic);
    exp_ic = exp_ic + 16'h0100;
  endtask

  task automatic t_irq();
    int i;
    wr(4'h4, 16'h0003);
    rd(4'h4, 16'h0000);
    wr(4'h5, 16'h0001);
    wr(4'h1, 16'hFFFF);
    wr(4'h3, 16'h0003);
    @(posedge mclk) seq_ready <= 1'b0;
    pulse(16'h0080);
    for (i = 0; i < 6; i++) begin
      @(negedge mclk);
      cmp("vector.load", 16'h0000, 16'(vector.load));
    end
    @(posedge mclk) seq_ready <= 1'b1;
    wait_load(7);
    rd(4'h2, save_exp);
    irq_chk(1'b1);
    wr(4'h5, 16'h0000);
    irq_chk(1'b0);
    wr(4'h5, 16'h0001);
    irq_chk(1'b1);
    wr(4'h4, 16'h0001);
    irq_chk(1'b0);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_vectors();
    t_priority();
    t_disable();
    t_mask();
    t_master_reset_in();
    t_sense();
    t_call();
    t_irq();
    wrap_up();
  end
endmodule
